// file: logic/tpc_pkg.sv
// Purpose: Constants and types for the 8-bit timer with PWM and capture
// Assumes: 8-bit register port, one 20 MHz clock
// Notes: Offsets are register addresses on the plain port
package tpc_pkg;
    // ****************
    // Register offsets
    // ****************
    localparam logic [7:0] TPC_OFS_CONTROL = 8'hB2;
    localparam logic [7:0] TPC_OFS_COUNT = 8'hB3;
    localparam logic [7:0] TPC_OFS_COMPARE = 8'hB4;
    localparam logic [7:0] TPC_OFS_IRQ_FLAG = 8'hB5;
    localparam logic [7:0] TPC_OFS_IRQ_MASK = 8'hB6;
    localparam logic [7:0] TPC_OFS_IRQ_POL = 8'hB7;
    // ****************
    // Reset values
    // ****************
    localparam logic [7:0] TPC_RST_CONTROL = 8'h00;
    localparam logic [7:0] TPC_RST_COUNT = 8'h00;
    localparam logic [7:0] TPC_RST_COMPARE = 8'hFF;
    localparam logic [7:0] TPC_RST_CAPTURE = 8'h00;
    localparam logic [7:0] TPC_RST_MASK = 8'h00;
    localparam logic [7:0] TPC_RST_POL = 8'h00;
    // ****************
    // Control fields
    // ****************
    localparam int TPC_BIT_ENABLE = 7;
    localparam int TPC_BIT_MODE_HI = 5;
    localparam int TPC_BIT_MODE_LO = 4;
    localparam int TPC_BIT_CLK_HI = 3;
    localparam int TPC_BIT_CLK_LO = 1;
    localparam int TPC_BIT_CLEAR = 0;
    localparam logic [7:0] TPC_CONTROL_WMASK = 8'hBE;
    // Flag register bit positions
    localparam int TPC_FLG_MATCH = 0;
    localparam int TPC_FLG_OVF = 1;
    localparam int TPC_FLG_CAPT = 2;
    localparam logic [7:0] TPC_FLAG_USED = 8'h07;
    // ****************
    // Prescaler
    // ****************
    localparam int TPC_PRE_W = 11;
    localparam logic [2:0] TPC_CLK_EXT = 3'h7;
    localparam logic [7:0] TPC_COUNT_MAX = 8'hFF;

    typedef enum logic [1:0] {
        TPC_MODE_TIMER = 2'b00,
        TPC_MODE_PWM = 2'b01,
        TPC_MODE_CAPT = 2'b10
    } tpc_mode_t;

    typedef struct packed {
        logic enable;
        logic spare;
        logic [1:0] mode;
        logic [2:0] clk_sel;
        logic clear;
    } tpc_control_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tpc_bus_req_t;
endpackage

// file: logic/tpc_timer.sv
// Purpose: 8-bit timer/counter with match toggle, PWM and input capture
// Assumes: One clock, pins synchronised here, plain register port
// Notes: Match and overflow flags sit in a shared flag register
`timescale 1ns/100ps
`default_nettype none
module tpc_timer
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire tpc_bus_req_t bus,
    output logic [7:0] rdata,
    // Pins
    input wire logic ext_clock_pin,
    input wire logic capture_input_pin,
    output logic toggle_output_pin,
    // Interrupt
    output logic irq
);
    // ****************
    // Declarations
    // ****************
    tpc_control_t control_r;
    logic [7:0] count_r;
    logic [7:0] compare_r;
    logic [7:0] capture_r;
    logic [7:0] flag_r;
    logic [7:0] mask_r;
    logic polarity_r;
    logic out_r;
    logic [TPC_PRE_W-1:0] pre_r;
    logic [TPC_PRE_W-1:0] pre_nxt;
    logic [2:0] ext_sync_r;
    logic [2:0] cap_sync_r;
    logic tick;
    logic int_tick;
    logic ext_rise;
    logic cap_edge;
    logic match;
    logic wrap;
    logic mode_pwm;
    logic mode_capt;
    logic mode_timer;
    logic wr_ctl;
    logic clr_req;
    logic rd_flag;
    logic [7:0] flag_set;

    // ****************
    // Decode
    // ****************
    assign wr_ctl = bus.wr && bus.addr == TPC_OFS_CONTROL;
    assign clr_req = wr_ctl && bus.wdata[TPC_BIT_CLEAR];
    assign rd_flag = bus.rd && bus.addr == TPC_OFS_IRQ_FLAG;
    assign mode_timer = control_r.enable && control_r.mode == TPC_MODE_TIMER;
    assign mode_pwm = control_r.enable && control_r.mode == TPC_MODE_PWM;
    assign mode_capt = control_r.enable && control_r.mode[1];

    // ****************
    // Pin synchronisers
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync_r <= 3'h0;
            cap_sync_r <= 3'h0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin};
            cap_sync_r <= {cap_sync_r[1:0], capture_input_pin};
        end
    end
    assign ext_rise = ext_sync_r[1] && !ext_sync_r[2];
    assign cap_edge = polarity_r ? (cap_sync_r[1] && !cap_sync_r[2])
                                 : (!cap_sync_r[1] && cap_sync_r[2]);

    // ****************
    // Prescaler
    // ****************
    assign pre_nxt = pre_r + 11'h001;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= '0;
        end else if (!control_r.enable) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    always_comb begin
        case (control_r.clk_sel)
            3'h0: int_tick = pre_nxt[0] && !pre_r[0];
            3'h1: int_tick = pre_nxt[1] && !pre_r[1];
            3'h2: int_tick = pre_nxt[2] && !pre_r[2];
            3'h3: int_tick = pre_nxt[4] && !pre_r[4];
            3'h4: int_tick = pre_nxt[6] && !pre_r[6];
            3'h5: int_tick = pre_nxt[8] && !pre_r[8];
            3'h6: int_tick = pre_nxt[10] && !pre_r[10];
            default: int_tick = 1'b0;
        endcase
    end
    assign tick = control_r.enable &&
                  (control_r.clk_sel == TPC_CLK_EXT ? ext_rise : int_tick);
    assign match = tick && count_r == compare_r;
    assign wrap = tick && mode_pwm && count_r == TPC_COUNT_MAX;

    // ****************
    // Control, compare, mask and polarity registers
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_r <= TPC_RST_CONTROL;
        end else if (wr_ctl) begin
            control_r <= bus.wdata & TPC_CONTROL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_r <= TPC_RST_COMPARE;
            mask_r <= TPC_RST_MASK;
            polarity_r <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == TPC_OFS_COMPARE) begin
                compare_r <= bus.wdata;
            end
            if (bus.addr == TPC_OFS_IRQ_MASK) begin
                mask_r <= bus.wdata & TPC_FLAG_USED;
            end
            if (bus.addr == TPC_OFS_IRQ_POL) begin
                polarity_r <= bus.wdata[0];
            end
        end
    end

    // ****************
    // Counter
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= TPC_RST_COUNT;
        end else if (clr_req) begin
            count_r <= 8'h00;
        end else if (match && !mode_pwm) begin
            count_r <= 8'h00;
        end else if (tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // ****************
    // Capture
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capture_r <= TPC_RST_CAPTURE;
        end else if (mode_capt && cap_edge) begin
            capture_r <= count_r;
        end
    end

    // ****************
    // Output pin
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_r <= 1'b0;
        end else if (mode_timer) begin
            if (match) begin
                out_r <= !out_r;
            end
        end else if (mode_pwm) begin
            if (wrap || clr_req) begin
                out_r <= 1'b1;
            end else if (match) begin
                out_r <= 1'b0;
            end
        end else begin
            out_r <= 1'b0;
        end
    end
    assign toggle_output_pin = out_r;

    // ****************
    // Interrupt flags
    // ****************
    always_comb begin
        flag_set = 8'h00;
        flag_set[TPC_FLG_MATCH] = match;
        flag_set[TPC_FLG_OVF] = wrap;
        flag_set[TPC_FLG_CAPT] = mode_capt && cap_edge;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 8'h00;
        end else if (rd_flag) begin
            flag_r <= flag_set;
        end else begin
            flag_r <= flag_r | flag_set;
        end
    end
    assign irq = |(flag_r & mask_r);

    // ****************
    // Read port
    // ****************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                TPC_OFS_CONTROL: rdata <= control_r;
                TPC_OFS_COUNT: rdata <= count_r;
                TPC_OFS_COMPARE: rdata <= mode_capt ? capture_r : compare_r;
                TPC_OFS_IRQ_FLAG: rdata <= flag_r;
                TPC_OFS_IRQ_MASK: rdata <= mask_r;
                TPC_OFS_IRQ_POL: rdata <= {7'h00, polarity_r};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ****************
    // Assertion helpers
    // ****************
    logic [8:0] high_ticks_r;
    logic clean_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_ticks_r <= 9'h000;
            clean_r <= 1'b0;
        end else if (wrap) begin
            high_ticks_r <= 9'h000;
            clean_r <= 1'b1;
        end else if (!mode_pwm || clr_req || (bus.wr && bus.addr == TPC_OFS_COMPARE)) begin
            clean_r <= 1'b0;
        end else if (tick && out_r) begin
            high_ticks_r <= high_ticks_r + 9'h001;
        end
    end

    // ****************
    // Assertions
    // ****************
    a_match_clears: assert property (@(posedge clk) disable iff (!rstn)
        match && !mode_pwm && !clr_req |=> count_r == 8'h00)
        else $error("counter not cleared on match");
    a_clear_wins: assert property (@(posedge clk) disable iff (!rstn)
        clr_req |=> count_r == 8'h00 && !control_r.clear)
        else $error("clear did not zero counter");
    a_pwm_wraps: assert property (@(posedge clk) disable iff (!rstn)
        tick && mode_pwm && !clr_req && !wr_ctl |=> count_r == $past(count_r) + 8'h01)
        else $error("pwm counter did not advance");
    a_ovf_flag: assert property (@(posedge clk) disable iff (!rstn)
        wrap |=> flag_r[TPC_FLG_OVF])
        else $error("overflow flag missing");
    a_match_flag: assert property (@(posedge clk) disable iff (!rstn)
        match |=> flag_r[TPC_FLG_MATCH])
        else $error("match flag missing");
    a_toggle_out: assert property (@(posedge clk) disable iff (!rstn)
        match && mode_timer && !wr_ctl |=> toggle_output_pin != $past(toggle_output_pin))
        else $error("output did not toggle");
    a_pwm_low: assert property (@(posedge clk) disable iff (!rstn)
        match && mode_pwm && !wrap && !clr_req && !wr_ctl |=> !toggle_output_pin)
        else $error("pwm output not low after match");
    a_capt_quiet: assert property (@(posedge clk) disable iff (!rstn)
        mode_capt ##1 mode_capt |-> !toggle_output_pin)
        else $error("output active in capture mode");
    a_capt_load: assert property (@(posedge clk) disable iff (!rstn)
        mode_capt && cap_edge |=> capture_r == $past(count_r))
        else $error("capture value wrong");
    a_shared_read: assert property (@(posedge clk) disable iff (!rstn)
        bus.rd && bus.addr == TPC_OFS_COMPARE && mode_capt |=> rdata == $past(capture_r))
        else $error("shared address read wrong");
    a_disabled_hold: assert property (@(posedge clk) disable iff (!rstn)
        !control_r.enable && !clr_req |=> $stable(count_r))
        else $error("count moved while disabled");
    a_ext_step: assert property (@(posedge clk) disable iff (!rstn)
        control_r.enable && control_r.clk_sel == TPC_CLK_EXT && ext_rise && !match && !clr_req
        |=> count_r == $past(count_r) + 8'h01)
        else $error("external edge not counted");
    a_ext_idle: assert property (@(posedge clk) disable iff (!rstn)
        control_r.clk_sel == TPC_CLK_EXT && !ext_rise && !clr_req |=> $stable(count_r))
        else $error("count moved without external edge");
    a_tick_step: assert property (@(posedge clk) disable iff (!rstn)
        tick && !match && !clr_req |=> count_r == $past(count_r) + 8'h01)
        else $error("count did not step on tick");
    a_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
        !tick && !clr_req |=> $stable(count_r))
        else $error("count moved without tick");
    a_timer_hold: assert property (@(posedge clk) disable iff (!rstn)
        mode_timer && !match |=> toggle_output_pin == $past(toggle_output_pin))
        else $error("output toggled without match");
    a_pwm_runs: assert property (@(posedge clk) disable iff (!rstn)
        match && mode_pwm && !clr_req |=> count_r == $past(count_r) + 8'h01)
        else $error("pwm match cleared counter");
    a_pwm_match_flag: assert property (@(posedge clk) disable iff (!rstn)
        match && mode_pwm |=> flag_r[TPC_FLG_MATCH])
        else $error("pwm match flag missing");
    a_ovf_wrap: assert property (@(posedge clk) disable iff (!rstn)
        tick && mode_pwm && count_r == TPC_COUNT_MAX && !clr_req
        |=> count_r == 8'h00 && flag_r[TPC_FLG_OVF])
        else $error("wrap did not reach zero with flag");
    a_ovf_sticky: assert property (@(posedge clk) disable iff (!rstn)
        flag_r[TPC_FLG_OVF] && !rd_flag |=> flag_r[TPC_FLG_OVF])
        else $error("overflow flag lost");
    a_ovf_clear: assert property (@(posedge clk) disable iff (!rstn)
        rd_flag && !wrap |=> !flag_r[TPC_FLG_OVF])
        else $error("overflow flag not cleared by read");
    a_pwm_high: assert property (@(posedge clk) disable iff (!rstn)
        wrap |=> toggle_output_pin)
        else $error("pwm output not high after wrap");
    a_pwm_duty: assert property (@(posedge clk) disable iff (!rstn)
        wrap && clean_r && compare_r != TPC_COUNT_MAX |-> high_ticks_r == {1'b0, compare_r} + 9'h001)
        else $error("pwm high time wrong");
    a_clear_high: assert property (@(posedge clk) disable iff (!rstn)
        clr_req && mode_pwm |=> toggle_output_pin)
        else $error("pwm output not high after clear");
    a_capt_clears: assert property (@(posedge clk) disable iff (!rstn)
        match && mode_capt && !clr_req |=> count_r == 8'h00)
        else $error("capture mode match did not clear");
    a_capt_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(mode_capt && cap_edge) |=> $stable(capture_r))
        else $error("capture value moved without edge");
    a_capt_flag: assert property (@(posedge clk) disable iff (!rstn)
        mode_capt && cap_edge |=> flag_r[TPC_FLG_CAPT])
        else $error("capture flag missing");
    a_capt_clear: assert property (@(posedge clk) disable iff (!rstn)
        rd_flag && !(mode_capt && cap_edge) |=> !flag_r[TPC_FLG_CAPT])
        else $error("capture flag not cleared by read");
    a_compare_write: assert property (@(posedge clk) disable iff (!rstn)
        bus.wr && bus.addr == TPC_OFS_COMPARE |=> compare_r == $past(bus.wdata))
        else $error("compare write lost");
    a_compare_read: assert property (@(posedge clk) disable iff (!rstn)
        bus.rd && bus.addr == TPC_OFS_COMPARE && !mode_capt |=> rdata == $past(compare_r))
        else $error("compare read wrong");
    a_clear_bit_low: assert property (@(posedge clk) disable iff (!rstn)
        !control_r.clear)
        else $error("clear bit stuck high");
    a_match_sticky: assert property (@(posedge clk) disable iff (!rstn)
        flag_r[TPC_FLG_MATCH] && !rd_flag |=> flag_r[TPC_FLG_MATCH])
        else $error("match flag lost");
    a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
        rd_flag && !match |=> !flag_r[TPC_FLG_MATCH])
        else $error("match flag not cleared by read");
    c_pwm_wrap: cover property (@(posedge clk) disable iff (!rstn) wrap);
    c_timer_match: cover property (@(posedge clk) disable iff (!rstn) match && mode_timer);
    c_capture: cover property (@(posedge clk) disable iff (!rstn) mode_capt && cap_edge);
    c_irq: cover property (@(posedge clk) disable iff (!rstn) irq);
    c_pwm_duty: cover property (@(posedge clk) disable iff (!rstn) wrap && clean_r);
endmodule
`default_nettype wire

// file: dv/tpc_pin_model.sv
// Purpose: Far-side pin model: external count clock and capture source
// Assumes: Driven from the bench clock, changes just after rising edges
// Notes: Both pins idle low between bursts
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_model (
    // Clock
    input wire logic clk,
    // Pins toward the timer
    output logic ext_clock_pin,
    output logic capture_input_pin
);
    initial begin
        ext_clock_pin = 1'b0;
        capture_input_pin = 1'b0;
    end

    // Rising edges on the count pin, pin driven as an input of the timer
    task automatic ext_edges(input int n);
        for (int i = 0; i < n; i++) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // One rising-edge capture event, polarity set by the bench
    task automatic capture_pulse();
        capture_input_pin <= 1'b1;
        repeat (6) @(posedge clk);
        capture_input_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: dv/tpc_timer_tb_top.sv
// Purpose: Self-checking bench for the 8-bit timer with PWM and capture
// Assumes: 20 MHz clock, plain register port with one-cycle read latency
// Notes: Pins come from the pin model
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_tb_top;
    import tpc_pkg::*;
    logic clk;
    logic rstn;
    tpc_bus_req_t bus;
    logic [7:0] rdata;
    logic ext_clock_pin;
    logic capture_input_pin;
    logic toggle_output_pin;
    logic irq;
    int err_total;
    int samples_checked;
    logic [7:0] v;
    logic [7:0] ra [7] = '{8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB0};
    logic [7:0] re [7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    int dv [7] = '{2, 4, 8, 32, 128, 512, 2048};

    tpc_timer i_tpc_timer (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
        .toggle_output_pin(toggle_output_pin), .irq(irq));
    tpc_pin_model i_tpc_pin_model (.clk(clk), .ext_clock_pin(ext_clock_pin),
        .capture_input_pin(capture_input_pin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_rd(a, d);
        check($sformatf("reg %h", a), d, exp);
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        rstn = 1'b0;
        bus = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // ****************
        // Reset values, unmapped read
        // ****************
        for (int i = 0; i < 7; i++) rd_chk(ra[i], re[i]);
        // ****************
        // Timer mode, external clock
        // ****************
        bus_wr(8'hB4, 8'h02);
        bus_wr(8'hB6, 8'h01);
        bus_wr(8'hB2, 8'h8F);
        rd_chk(8'hB2, 8'h8E);
        i_tpc_pin_model.ext_edges(3);
        check("irq", {7'h0, irq}, 8'h01);
        check("toggle", {7'h0, toggle_output_pin}, 8'h01);
        rd_chk(8'hB3, 8'h00);
        rd_chk(8'hB5, 8'h01);
        check("irq", {7'h0, irq}, 8'h00);
        i_tpc_pin_model.ext_edges(3);
        check("toggle", {7'h0, toggle_output_pin}, 8'h00);
        // ****************
        // Capture mode, code 11
        // ****************
        bus_wr(8'hB7, 8'h01);
        bus_wr(8'hB6, 8'h04);
        bus_wr(8'hB2, 8'hBF);
        bus_wr(8'hB4, 8'h07);
        i_tpc_pin_model.ext_edges(5);
        rd_chk(8'hB3, 8'h05);
        i_tpc_pin_model.capture_pulse();
        check("irq", {7'h0, irq}, 8'h01);
        rd_chk(8'hB4, 8'h05);
        rd_chk(8'hB5, 8'h05);
        check("toggle", {7'h0, toggle_output_pin}, 8'h00);
        i_tpc_pin_model.ext_edges(3);
        rd_chk(8'hB3, 8'h00);
        rd_chk(8'hB5, 8'h01);
        // ****************
        // PWM mode
        // ****************
        bus_wr(8'hB4, 8'h80);
        bus_wr(8'hB6, 8'h02);
        bus_wr(8'hB2, 8'h91);
        wait_irq();
        check("toggle", {7'h0, toggle_output_pin}, 8'h01);
        rd_chk(8'hB5, 8'h03);
        repeat (300) @(posedge clk);
        check("toggle", {7'h0, toggle_output_pin}, 8'h00);
        wait_irq();
        check("toggle", {7'h0, toggle_output_pin}, 8'h01);
        bus_wr(8'hB2, 8'h9D);
        rd_chk(8'hB3, 8'h00);
        check("toggle", {7'h0, toggle_output_pin}, 8'h01);
        // ****************
        // Prescaler codes
        // ****************
        bus_wr(8'hB4, 8'hFF);
        for (int c = 0; c < 7; c++) begin
            bus_wr(8'hB2, 8'h00);
            bus_wr(8'hB2, 8'h81 | 8'(c << 1));
            repeat (4 * dv[c] + dv[c] / 2) @(posedge clk);
            bus_rd(8'hB3, v);
            check("div", {7'h0, v inside {[8'h03 : 8'h05]}}, 8'h01);
        end
        bus_wr(8'hB2, 8'hA0);
        rd_chk(8'hB4, 8'h05);
        complete_run();
    end
endmodule
`default_nettype wire
